/* File: sq_pkg.sv */
// Purpose : constants and types for the sample clock and record qualifier front end
// Assumes : APB register access, 25 MHz reference clock, 32 probe channels
// Notes   : all offsets are byte addresses of aligned 32-bit words
package sq_pkg;

  // -------------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_PERIOD  = 8'h04;
  localparam logic [7:0] OFS_QSEL    = 8'h08;
  localparam logic [7:0] OFS_DELAY   = 8'h0C;
  localparam logic [7:0] OFS_WIDTH   = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_RATE    = 8'h18;
  localparam logic [7:0] OFS_TRIGPOS = 8'h1C;

  // ctrl fields
  localparam int CTRL_SRC_BIT   = 0;
  localparam int CTRL_EDGE_BIT  = 1;
  localparam int CTRL_QUAL_LSB  = 2;
  localparam int CTRL_DQ_LSB    = 4;
  localparam int CTRL_INV_BIT   = 6;
  localparam int CTRL_START_BIT = 8;
  localparam int CTRL_STOP_BIT  = 9;
  // period, qualifier select and status fields
  localparam int PER_UNIT_LSB   = 16;
  localparam int QSEL_COMB_LSB  = 0;
  localparam int QSEL_EN_LSB    = 4;
  localparam int QSEL_DIS_LSB   = 8;
  localparam int ST_RUN_BIT     = 0;
  localparam int ST_TRIG_BIT    = 1;
  localparam int ST_DONE_BIT    = 2;
  localparam int ST_REFUSED_BIT = 3;
  localparam int ST_STORE_BIT   = 4;
  localparam int ST_MASK_LSB    = 8;
  localparam int ST_ADDR_LSB    = 16;

  // -------------------------------------------------------------------------
  // encodings and limits
  // -------------------------------------------------------------------------
  localparam logic       SRC_INT = 1'b0;
  localparam logic       EDGE_RISE = 1'b1;
  localparam logic [1:0] QV_LOW = 2'h0, QV_HIGH = 2'h1, QV_ALWAYS = 2'h2;
  localparam logic [1:0] DQ_OFF = 2'h0, DQ_COMB = 2'h1, DQ_STATE = 2'h2;
  localparam logic [1:0] UNIT_NS = 2'h0, UNIT_US = 2'h1, UNIT_MS = 2'h2;
  localparam logic [1:0] WC_4 = 2'h0, WC_8 = 2'h1, WC_16 = 2'h2, WC_32 = 2'h3;
  localparam int         DELAY_W = 17;
  localparam int         ADDR_W  = 13;
  localparam int         CYC_W   = 24;
  localparam logic [ADDR_W-1:0] DEPTH_4 = 13'h1F40, DEPTH_8 = 13'h0FA0;
  localparam logic [ADDR_W-1:0] DEPTH_16 = 13'h07D0, DEPTH_32 = 13'h03E8;
  localparam logic [47:0] MIN_NS_4 = 48'h00000000000A, MIN_NS_8 = 48'h000000000014;
  localparam logic [47:0] MIN_NS_16 = 48'h000000000028, MIN_NS_32 = 48'h000000000050;
  localparam logic [47:0] MULT_US = 48'h0000000003E8, MULT_MS = 48'h0000000F4240;
  localparam int          REF_PERIOD_NS = 40;
  localparam logic [47:0] REF_NS = 48'(REF_PERIOD_NS);
  localparam logic [DELAY_W:0] PIPE_CLOCKS = 18'h00011;
  localparam int          PERIOD_MAX_NS = 200_000_000;

  // -------------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------------
  localparam logic [15:0] PER_VAL_RST = 16'h000A;
  localparam logic [1:0]  WC_RST      = WC_32;

  // setup held by software
  typedef struct packed {
    logic               src;
    logic               edge_sel;
    logic [1:0]         qual;
    logic [1:0]         dq;
    logic               inv;
    logic [1:0]         wc;
    logic [3:0]         comb_sel;
    logic [3:0]         en_sel;
    logic [3:0]         dis_sel;
    logic [DELAY_W-1:0] delay;
    logic [15:0]        per_val;
    logic [1:0]         per_unit;
  } sq_cfg_t;

  typedef enum logic [1:0] {ACQ_IDLE, ACQ_RUN, ACQ_POST} sq_acq_t;

endpackage : sq_pkg

/* File: sq_front_end.sv */
// Purpose : sample clock selection, record width and per-sample qualification
// Assumes : word_hit_i and trig_cond_i answer combinationally to sample_o
// Notes   : zero-wait APB slave; memory write port drives an external RAM
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module sq_front_end #(
  parameter int unsigned MAX_PERIOD_NS = sq_pkg::PERIOD_MAX_NS
) (
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [7:0]                paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic      [31:0]               prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  input  wire logic                      ext_clk_i,
  input  wire logic                      ext_qual_i,
  input  wire logic [31:0]               probe_i,
  input  wire logic [3:0]                word_hit_i,
  input  wire logic                      trig_cond_i,
  output logic      [31:0]               sample_o,
  output logic                           sample_stb_o,
  output logic      [3:0]                seq_word_mask_o,
  output logic                           mem_we_o,
  output logic      [sq_pkg::ADDR_W-1:0] mem_addr_o,
  output logic      [31:0]               mem_data_o,
  output logic                           acq_running_o
);
  import sq_pkg::*;

  // -------------------------------------------------------------------------
  // helper functions
  // -------------------------------------------------------------------------
  // number of selected words in a field
  function automatic logic [2:0] sq_count(input logic [3:0] sel);
    sq_count = {2'b00, sel[0]} + {2'b00, sel[1]} + {2'b00, sel[2]} + {2'b00, sel[3]};
  endfunction : sq_count

  // requested channel count to width code, rounding up
  function automatic logic [1:0] sq_round_width(input logic [31:0] req);
    if (req <= 32'h4)
      sq_round_width = WC_4;
    else if (req <= 32'h8)
      sq_round_width = WC_8;
    else if (req <= 32'h10)
      sq_round_width = WC_16;
    else
      sq_round_width = WC_32;
  endfunction : sq_round_width

  // record depth for a width code
  function automatic logic [ADDR_W-1:0] sq_depth(input logic [1:0] wc);
    unique case (wc)
      WC_4:    sq_depth = DEPTH_4;
      WC_8:    sq_depth = DEPTH_8;
      WC_16:   sq_depth = DEPTH_16;
      default: sq_depth = DEPTH_32;
    endcase
  endfunction : sq_depth

  // requested period to nearest achievable count of reference cycles
  function automatic logic [CYC_W-1:0] sq_period_cycles(input logic [15:0] val, input logic [1:0] unit,
                                                        input logic [1:0] wc);
    logic [47:0] ns;
    logic [47:0] lo;
    logic [47:0] cyc;
    ns = 48'h0;
    lo = MIN_NS_32;
    cyc = 48'h0;
    unique case (unit)
      UNIT_US: ns = 48'({32'h0, val} * MULT_US);
      UNIT_MS: ns = 48'({32'h0, val} * MULT_MS);
      default: ns = {32'h0, val};
    endcase
    unique case (wc)
      WC_4:    lo = MIN_NS_4;
      WC_8:    lo = MIN_NS_8;
      WC_16:   lo = MIN_NS_16;
      default: lo = MIN_NS_32;
    endcase
    if (ns < lo)
      ns = lo;
    if (ns > 48'(MAX_PERIOD_NS))
      ns = 48'(MAX_PERIOD_NS);
    cyc = (ns + (REF_NS >> 1)) / REF_NS;
    if (cyc == 48'h0)
      cyc = 48'h1;
    sq_period_cycles = cyc[CYC_W-1:0];
  endfunction : sq_period_cycles

  // -------------------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------------------
  sq_cfg_t           cfg_reg;
  sq_acq_t           acq_reg;
  logic [CYC_W-1:0]  period_cyc_reg;
  logic [CYC_W-1:0]  int_cnt_reg;
  logic              clk_s1_reg, clk_s2_reg, clk_s3_reg;
  logic              qual_s1_reg, qual_s2_reg;
  logic [31:0]       probe_s1_reg, probe_s2_reg;
  logic [31:0]       sample_reg;
  logic              stb_reg;
  logic              store_en_reg;
  logic              trig_reg, done_reg, refused_reg;
  logic [DELAY_W:0]  post_cnt_reg;
  logic [DELAY_W:0]  target_reg;
  logic [ADDR_W-1:0] addr_reg, trig_pos_reg;
  logic              mem_we_reg;
  logic [ADDR_W-1:0] mem_addr_reg;
  logic [31:0]       mem_data_reg;
  logic [3:0]        mask_reg;
  logic [31:0]       prdata_reg;
  logic              wr_acc, rd_setup, hit_map;
  logic              start_req, stop_req, start_bad;
  logic              running, ext_edge, qual_ok, tick, int_tick;
  logic [1:0]        dq_eff;
  logic              comb_any, en_hit, dis_hit, state_next, qualified, store;
  logic [DELAY_W:0]  target_next;
  logic [31:0]       width_mask;

  // -------------------------------------------------------------------------
  // APB slave
  // -------------------------------------------------------------------------
  // address decode and strobes
  assign hit_map   = (paddr_i[7:5] == 3'h0) && (paddr_i[1:0] == 2'h0);
  assign wr_acc    = psel_i && penable_i && pwrite_i && hit_map;
  assign rd_setup  = psel_i && !penable_i && !pwrite_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !hit_map;
  assign prdata_o  = prdata_reg;
  assign start_req = wr_acc && (paddr_i == OFS_CTRL) && pwdata_i[CTRL_START_BIT];
  assign stop_req  = wr_acc && (paddr_i == OFS_CTRL) && pwdata_i[CTRL_STOP_BIT];

  // configuration writes
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_reg         <= '0;
      cfg_reg.wc      <= WC_RST;
      cfg_reg.per_val <= PER_VAL_RST;
      cfg_reg.qual    <= QV_ALWAYS;
    end else if (wr_acc) begin
      unique case (paddr_i)
        OFS_CTRL: begin
          cfg_reg.src      <= pwdata_i[CTRL_SRC_BIT];
          cfg_reg.edge_sel <= pwdata_i[CTRL_EDGE_BIT];
          cfg_reg.qual     <= pwdata_i[CTRL_QUAL_LSB +: 2];
          cfg_reg.dq       <= pwdata_i[CTRL_DQ_LSB +: 2];
          cfg_reg.inv      <= pwdata_i[CTRL_INV_BIT];
        end
        OFS_PERIOD: begin
          cfg_reg.per_val  <= pwdata_i[15:0];
          cfg_reg.per_unit <= pwdata_i[PER_UNIT_LSB +: 2];
        end
        OFS_QSEL: begin
          cfg_reg.comb_sel <= pwdata_i[QSEL_COMB_LSB +: 4];
          cfg_reg.en_sel   <= pwdata_i[QSEL_EN_LSB +: 4];
          cfg_reg.dis_sel  <= pwdata_i[QSEL_DIS_LSB +: 4];
        end
        OFS_DELAY: cfg_reg.delay <= pwdata_i[DELAY_W-1:0];
        OFS_WIDTH: cfg_reg.wc <= sq_round_width(pwdata_i);
        default: ;
      endcase
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_reg <= 32'h0;
    end else if (rd_setup) begin
      prdata_reg <= 32'h0;
      unique case (paddr_i)
        OFS_CTRL: begin
          prdata_reg[CTRL_SRC_BIT]        <= cfg_reg.src;
          prdata_reg[CTRL_EDGE_BIT]       <= cfg_reg.edge_sel;
          prdata_reg[CTRL_QUAL_LSB +: 2]  <= cfg_reg.qual;
          prdata_reg[CTRL_DQ_LSB +: 2]    <= cfg_reg.dq;
          prdata_reg[CTRL_INV_BIT]        <= cfg_reg.inv;
        end
        OFS_PERIOD: prdata_reg <= {14'h0, cfg_reg.per_unit, cfg_reg.per_val};
        OFS_QSEL:   prdata_reg <= {20'h0, cfg_reg.dis_sel, cfg_reg.en_sel, cfg_reg.comb_sel};
        OFS_DELAY:  prdata_reg <= {15'h0, cfg_reg.delay};
        OFS_WIDTH:  prdata_reg <= 32'h4 << cfg_reg.wc;
        OFS_STATUS: begin
          prdata_reg[ST_RUN_BIT]          <= running;
          prdata_reg[ST_TRIG_BIT]         <= trig_reg;
          prdata_reg[ST_DONE_BIT]         <= done_reg;
          prdata_reg[ST_REFUSED_BIT]      <= refused_reg;
          prdata_reg[ST_STORE_BIT]        <= store_en_reg;
          prdata_reg[ST_MASK_LSB +: 4]    <= mask_reg;
          prdata_reg[ST_ADDR_LSB +: ADDR_W] <= addr_reg;
        end
        OFS_RATE:    prdata_reg <= {8'h0, period_cyc_reg};
        OFS_TRIGPOS: prdata_reg <= {19'h0, trig_pos_reg};
        default: ;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // sample clock
  // -------------------------------------------------------------------------
  // nearest achievable internal period, clamped to the width's top rate
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      period_cyc_reg <= 24'h000001;
    else
      period_cyc_reg <= sq_period_cycles(cfg_reg.per_val, cfg_reg.per_unit, cfg_reg.wc);
  end

  // internal period generator, first tick period_cyc_reg - 1 cycles after start
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      int_cnt_reg <= 24'h000000;
    else if (!running || int_tick)
      int_cnt_reg <= period_cyc_reg - 24'h000001;
    else
      int_cnt_reg <= int_cnt_reg - 24'h000001;
  end
  assign int_tick = running && (int_cnt_reg == 24'h000000);

  // pin synchronisers, stage two feeds the logic, clock stages two and three feed the edge detect
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_s1_reg   <= 1'b0;
      clk_s2_reg   <= 1'b0;
      clk_s3_reg   <= 1'b0;
      qual_s1_reg  <= 1'b0;
      qual_s2_reg  <= 1'b0;
      probe_s1_reg <= 32'h0;
      probe_s2_reg <= 32'h0;
    end else begin
      clk_s1_reg   <= ext_clk_i;
      clk_s2_reg   <= clk_s1_reg;
      clk_s3_reg   <= clk_s2_reg;
      qual_s1_reg  <= ext_qual_i;
      qual_s2_reg  <= qual_s1_reg;
      probe_s1_reg <= probe_i;
      probe_s2_reg <= probe_s1_reg;
    end
  end

  // external edge select and qualifier
  assign ext_edge = (cfg_reg.edge_sel == EDGE_RISE) ? (clk_s2_reg && !clk_s3_reg)
                                                    : (!clk_s2_reg && clk_s3_reg);
  always_comb begin
    unique case (cfg_reg.qual)
      QV_LOW:    qual_ok = !qual_s2_reg;
      QV_HIGH:   qual_ok = qual_s2_reg;
      QV_ALWAYS: qual_ok = 1'b1;
      default:   qual_ok = 1'b1;
    endcase
  end
  assign tick = (cfg_reg.src == SRC_INT) ? int_tick : (running && ext_edge && qual_ok);

  // -------------------------------------------------------------------------
  // sample capture
  // -------------------------------------------------------------------------
  assign width_mask = (cfg_reg.wc == WC_32) ? 32'hFFFFFFFF : ((32'h1 << (32'h4 << cfg_reg.wc)) - 32'h1);

  // sample register offered to the word matcher
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sample_reg <= 32'h0;
      stb_reg    <= 1'b0;
    end else begin
      stb_reg <= tick;
      if (tick)
        sample_reg <= probe_s2_reg & width_mask;
    end
  end
  assign sample_o     = sample_reg;
  assign sample_stb_o = stb_reg;

  // -------------------------------------------------------------------------
  // qualification
  // -------------------------------------------------------------------------
  assign dq_eff     = (cfg_reg.wc == WC_32) ? cfg_reg.dq : DQ_OFF;
  assign comb_any   = |(word_hit_i & cfg_reg.comb_sel);
  assign en_hit     = |(word_hit_i & cfg_reg.en_sel);
  assign dis_hit    = |(word_hit_i & cfg_reg.dis_sel);
  assign state_next = en_hit ? 1'b1 : (dis_hit ? 1'b0 : store_en_reg);

  // per-sample store decision
  always_comb begin
    unique case (dq_eff)
      DQ_OFF:   qualified = 1'b1;
      DQ_COMB:  qualified = cfg_reg.inv ? !comb_any : comb_any;
      DQ_STATE: qualified = state_next;
      default:  qualified = 1'b1;
    endcase
  end
  assign store = running && stb_reg && qualified;

  // state-mode record enable, on at each start
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      store_en_reg <= 1'b1;
    else if (start_req)
      store_en_reg <= 1'b1;
    else if (running && stb_reg && dq_eff == DQ_STATE)
      store_en_reg <= state_next;
  end

  // words left to the trigger sequence
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      mask_reg <= 4'hF;
    else if (dq_eff == DQ_STATE)
      mask_reg <= {1'b0, !(sq_count(cfg_reg.en_sel) == 3'h2 || sq_count(cfg_reg.dis_sel) == 3'h2), 2'b11};
    else
      mask_reg <= 4'hF;
  end
  assign seq_word_mask_o = mask_reg;

  // -------------------------------------------------------------------------
  // acquisition control
  // -------------------------------------------------------------------------
  assign running     = (acq_reg != ACQ_IDLE);
  assign start_bad   = (cfg_reg.wc == WC_32) && (pwdata_i[CTRL_DQ_LSB +: 2] == DQ_STATE) &&
                       (sq_count(cfg_reg.en_sel) > 3'h2 || sq_count(cfg_reg.dis_sel) > 3'h2);
  // external clock adds the pipeline clocks so the delay lands where set
  assign target_next = {1'b0, cfg_reg.delay} + ((cfg_reg.src == SRC_INT) ? '0 : PIPE_CLOCKS);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acq_reg      <= ACQ_IDLE;
      trig_reg     <= 1'b0;
      done_reg     <= 1'b0;
      refused_reg  <= 1'b0;
      post_cnt_reg <= '0;
      target_reg   <= '0;
      trig_pos_reg <= '0;
    end else if (stop_req) begin
      acq_reg <= ACQ_IDLE;
    end else if (start_req) begin
      refused_reg <= start_bad;
      acq_reg     <= start_bad ? ACQ_IDLE : ACQ_RUN;
      trig_reg    <= 1'b0;
      done_reg    <= 1'b0;
    end else begin
      unique case (acq_reg)
        ACQ_IDLE: ;
        ACQ_RUN: begin
          // trigger seen on every sample, stored or not
          if (stb_reg && trig_cond_i) begin
            trig_reg     <= 1'b1;
            trig_pos_reg <= addr_reg;
            target_reg   <= target_next;
            post_cnt_reg <= '0;
            if (target_next == '0) begin
              acq_reg  <= ACQ_IDLE;
              done_reg <= 1'b1;
            end else begin
              acq_reg <= ACQ_POST;
            end
          end
        end
        ACQ_POST: begin
          // delay counts only stored samples
          if (store) begin
            post_cnt_reg <= post_cnt_reg + 18'h00001;
            if (post_cnt_reg + 18'h00001 == target_reg) begin
              acq_reg  <= ACQ_IDLE;
              done_reg <= 1'b1;
            end
          end
        end
      endcase
    end
  end
  assign acq_running_o = running;

  // -------------------------------------------------------------------------
  // memory write port
  // -------------------------------------------------------------------------
  // address wraps within the depth of the current width
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      addr_reg <= '0;
    else if (start_req)
      addr_reg <= '0;
    else if (store)
      addr_reg <= (addr_reg >= sq_depth(cfg_reg.wc) - 13'h0001) ? '0 : addr_reg + 13'h0001;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_we_reg   <= 1'b0;
      mem_addr_reg <= '0;
      mem_data_reg <= 32'h0;
    end else begin
      mem_we_reg <= store;
      if (store) begin
        mem_addr_reg <= addr_reg;
        mem_data_reg <= sample_reg;
      end
    end
  end
  assign mem_we_o   = mem_we_reg;
  assign mem_addr_o = mem_addr_reg;
  assign mem_data_o = mem_data_reg;

endmodule : sq_front_end

`default_nettype wire

/* File: sq_front_end_props.sv */
// Purpose : port level checks of the sample front end
// Assumes : one clock domain, reset async and active low
// Notes   : bound onto every sq_front_end instance
`timescale 1ns/1ps
`default_nettype none
module sq_front_end_props
  import sq_pkg::*;
(
  input wire logic              ref_clk_i,
  input wire logic              rst_n_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [7:0]        paddr_i,
  input wire logic [31:0]       prdata_o,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  input wire logic [31:0]       sample_o,
  input wire logic              sample_stb_o,
  input wire logic              mem_we_o,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire logic [31:0]       mem_data_o,
  input wire logic              acq_running_o
);
  logic [ADDR_W-1:0] last_reg;
  logic              seen_reg;
  // last written address
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_reg <= '0;
      seen_reg <= 1'b0;
    end else if (mem_we_o) begin
      last_reg <= mem_addr_o;
      seen_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // stored sample then its write
  sequence s_store;
    sample_stb_o ##1 mem_we_o;
  endsequence
  apb_ready_a: assert property (psel_i |-> pready_o) else $error("pready low in transfer");
  apb_err_a: assert property (psel_i && penable_i && paddr_i[1:0] != 2'h0 |->
    pslverr_o && (pwrite_i || prdata_o == 32'h0)) else $error("unaligned access not refused");
  apb_ok_a: assert property (psel_i && penable_i && paddr_i <= 8'h1C && paddr_i[1:0] == 2'h0 |-> !pslverr_o)
    else $error("mapped access refused");
  we_cause_a: assert property (mem_we_o |-> $past(sample_stb_o)) else $error("write without sample");
  store_data_a: assert property (s_store |-> mem_data_o == $past(sample_o)) else $error("written data differs");
  stb_run_a: assert property (sample_stb_o |-> $past(acq_running_o)) else $error("sample while idle");
  addr_depth_a: assert property (mem_addr_o < DEPTH_4) else $error("address beyond depth");
  addr_step_a: assert property (mem_we_o && seen_reg |-> mem_addr_o == last_reg + 13'h1 || mem_addr_o == 13'h0)
    else $error("address did not step");
  cover property (s_store);
endmodule : sq_front_end_props
bind sq_front_end sq_front_end_props i_props (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .sample_o(sample_o), .sample_stb_o(sample_stb_o), .mem_we_o(mem_we_o),
  .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o), .acq_running_o(acq_running_o));
`default_nettype wire

/* File: sq_target_model.sv */
// Purpose : target system driving probes, clock and qualifier
// Assumes : clock starts once run_i is high and stops at the end of the period in which run_i falls
// Notes   : data and qualifier move on the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module sq_target_model (
  input  wire logic        run_i,
  output logic             ext_clk_o,
  output logic             ext_qual_o,
  output logic [31:0]      probe_o
);
  logic [1:0] edges;
  initial begin
    ext_clk_o = 1'b0;
    ext_qual_o = 1'b1;
    probe_o = 32'h0;
    edges = 2'h0;
  end
  // 320 ns clock well under the rate limit, still between frames, edges off the reference grid
  always begin
    wait (run_i);
    #10;
    while (run_i) begin
      #160 ext_clk_o = 1'b1;
      #160 ext_clk_o = 1'b0;
      edges = edges + 2'h1;
      ext_qual_o = edges[1];
      probe_o = probe_o + 32'h1357_9BDF;
    end
  end
endmodule : sq_target_model
`default_nettype wire

/* File: sq_front_end_bench.sv */
// Purpose : self checking bench of the sample front end
// Assumes : matcher answers combinationally from a strobe count
// Notes   : period limit lowered to 4000 ns
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module sq_front_end_bench;
  import sq_pkg::*;
  logic              ref_clk_i = 1'b0, rst_n_i = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic              ext_run = 1'b0, clr = 1'b0, pready, pslverr, stb, we, running, ext_clk, ext_qual, err;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0, prdata, sample, mdata, probe, rd_v;
  logic [3:0]        mask, hit;
  logic [ADDR_W-1:0] maddr;
  int                n_stb, n_we, hmode = 0, trig_at = 99, n_mismatch = 0, checks = 0;
  int                wi[6] = '{1, 5, 8, 9, 17, 33}, wo[6] = '{4, 8, 8, 16, 32, 32};
  always #20 ref_clk_i = ~ref_clk_i;
  // trigger word hits by strobe count
  assign hit = hmode == 1 ? {2'b00, ~n_stb[0], 1'b0} : hmode == 2 ? {n_stb == 2, n_stb == 5, 2'b00} : 4'h0;
  // strobes and stores of the current run
  always_ff @(posedge ref_clk_i) begin
    n_stb <= clr ? 0 : n_stb + int'(stb);
    n_we <= clr ? 0 : n_we + int'(we);
  end
  sq_front_end #(.MAX_PERIOD_NS(4000)) i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .ext_clk_i(ext_clk), .ext_qual_i(ext_qual), .probe_i(probe), .word_hit_i(hit), .trig_cond_i(stb && n_stb == trig_at),
    .sample_o(sample), .sample_stb_o(stb), .seq_word_mask_o(mask), .mem_we_o(we), .mem_addr_o(maddr),
    .mem_data_o(mdata), .acq_running_o(running));
  sq_target_model i_tgt (.run_i(ext_run), .ext_clk_o(ext_clk), .ext_qual_o(ext_qual), .probe_o(probe));
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    pen <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    rd_v = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  // configure, start, wait for stop, count stores
  task automatic run(input logic [31:0] c, q, d, w, input int hm, ta, ex, input logic [3:0] em);
    hmode = hm;
    trig_at = ta;
    apb(1'b1, OFS_WIDTH, w);
    apb(1'b1, OFS_QSEL, q);
    apb(1'b1, OFS_DELAY, d);
    clr <= 1'b1;
    ext_run <= c[0];
    apb(1'b1, OFS_CTRL, c | 32'h100);
    clr <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    if (em != 4'h0) `CHK(mask, em)
    for (int i = 0; i < 4000 && running === 1'b1; i++) @(posedge ref_clk_i);
    repeat (3) @(posedge ref_clk_i);
    ext_run <= 1'b0;
    `CHK(running, 1'b0)
    `CHK(n_we, ex)
  endtask : run
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // watchdog
  initial begin
    repeat (40000) @(posedge ref_clk_i);
    n_mismatch++;
    test_done();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0); `CHK(rd_v, 32'h8)
    apb(1'b0, OFS_PERIOD, 32'h0); `CHK(rd_v, 32'hA)
    apb(1'b0, OFS_WIDTH, 32'h0); `CHK(rd_v, 32'h20)
    apb(1'b1, OFS_RATE, 32'h5);
    apb(1'b0, OFS_RATE, 32'h0); `CHK(rd_v, 32'h2)
    apb(1'b0, 8'h22, 32'h0); `CHK({err, rd_v}, {1'b1, 32'h0})
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, OFS_WIDTH, 32'(wi[i]));
      apb(1'b0, OFS_WIDTH, 32'h0); `CHK(rd_v, 32'(wo[i]))
    end
    apb(1'b1, OFS_WIDTH, 32'h4);
    apb(1'b0, OFS_RATE, 32'h0); `CHK(rd_v, 32'h1)
    apb(1'b1, OFS_WIDTH, 32'h20);
    apb(1'b1, OFS_PERIOD, 32'h78);
    apb(1'b0, OFS_RATE, 32'h0); `CHK(rd_v, 32'h3)
    apb(1'b1, OFS_PERIOD, 32'h10001);
    apb(1'b0, OFS_RATE, 32'h0); `CHK(rd_v, 32'h19)
    apb(1'b1, OFS_PERIOD, 32'h20002);
    apb(1'b0, OFS_RATE, 32'h0); `CHK(rd_v, 32'h64)
    apb(1'b1, OFS_PERIOD, 32'hA);
    run(32'h8, 32'h0, 32'h3, 32'h20, 0, 4, 8, 4'h0);
    run(32'h8, 32'h0, 32'h0, 32'h20, 0, 4, 5, 4'h0);
    run(32'h0, 32'h0, 32'h0, 32'h20, 0, 4, 5, 4'h0);
    run(32'h4, 32'h0, 32'h0, 32'h20, 0, 4, 5, 4'h0);
    run(32'h18, 32'h3, 32'h2, 32'h20, 1, 8, 7, 4'h0);
    run(32'h58, 32'h3, 32'h2, 32'h20, 1, 8, 6, 4'h0);
    run(32'h28, 32'h840, 32'h0, 32'h20, 2, 7, 5, 4'h7);
    run(32'h28, 32'h860, 32'h0, 32'h20, 2, 7, 5, 4'h3);
    run(32'h28, 32'h70, 32'h0, 32'h20, 0, 99, 0, 4'h0);
    apb(1'b0, OFS_STATUS, 32'h0); `CHK(rd_v[3:0], 4'h8)
    apb(1'b1, OFS_CTRL, 32'h108);
    apb(1'b0, OFS_STATUS, 32'h0); `CHK(rd_v[3:0], 4'h1)
    apb(1'b1, OFS_CTRL, 32'h208);
    apb(1'b0, OFS_STATUS, 32'h0); `CHK(rd_v[3:0], 4'h0)
    run(32'h18, 32'h1, 32'h0, 32'h10, 0, 4, 5, 4'h0);
    run(32'hB, 32'h0, 32'h1, 32'h20, 0, 2, 21, 4'h0);
    apb(1'b0, OFS_TRIGPOS, 32'h0); `CHK(rd_v, 32'h2)
    run(32'h5, 32'h0, 32'h1, 32'h20, 0, 2, 21, 4'h0);
    run(32'h1, 32'h0, 32'h1, 32'h20, 0, 2, 21, 4'h0);
    test_done();
  end
endmodule : sq_front_end_bench
`undef CHK
`default_nettype wire
